// ### shared/cbcd_pkg.sv
// Constants, encodings and carrier types for the compare/branch, coprocessor,
// leading-zero and compare-negative decode block.
// Assumes a core that supplies fetched words, register values and a flag set.
package cbcd_pkg;

   // ****************************************
   // Timing and widths
   // ****************************************
   localparam int          CBCD_PC_AHEAD      = 4;
   localparam logic [31:0] CBCD_PC_AHEAD_W    = 32'h0000_0004;
   localparam logic [31:0] CBCD_RESET_WORD    = 32'h0000_0000;
   localparam logic [3:0]  CBCD_RESET_FLAGS   = 4'h0;
   localparam logic [5:0]  CBCD_ZERO_COUNT    = 6'h20;
   localparam int          CBCD_FAULT_CYCLES  = 1;

   // ****************************************
   // Opcode masks and matches
   // ****************************************
   localparam logic [15:0] CBCD_BR_MASK       = 16'hF500;
   localparam logic [15:0] CBCD_BR_MATCH      = 16'hB100;
   localparam logic [15:0] CBCD_CMNR16_MASK   = 16'hFFC0;
   localparam logic [15:0] CBCD_CMNR16_MATCH  = 16'h42C0;
   localparam logic [31:0] CBCD_CDP_MASK      = 32'hEF00_0010;
   localparam logic [31:0] CBCD_CDP_MATCH     = 32'hEE00_0000;
   localparam logic [31:0] CBCD_CLEAR_EXCLUSIVE_MONITOR_MASK    = 32'hFFFF_FFFF;
   localparam logic [31:0] CBCD_CLEAR_EXCLUSIVE_MONITOR_MATCH   = 32'hF3BF_8F2F;
   localparam logic [31:0] CBCD_CLZ_MASK      = 32'hFFF0_F0F0;
   localparam logic [31:0] CBCD_CLZ_MATCH     = 32'hFAB0_F080;
   localparam logic [31:0] CBCD_CMNI_MASK     = 32'hFBF0_8F00;
   localparam logic [31:0] CBCD_CMNI_MATCH    = 32'hF110_0F00;
   localparam logic [31:0] CBCD_CMNR32_MASK   = 32'hFFF0_8F00;
   localparam logic [31:0] CBCD_CMNR32_MATCH  = 32'hEB10_0F00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CBCD_POS_POLARITY = 11;
   localparam int CBCD_POS_BR_I     = 9;
   localparam int CBCD_POS_ALT      = 28;
   localparam int CBCD_POS_SP       = 13;
   localparam int CBCD_POS_PC       = 15;

   // ****************************************
   // Shift kinds
   // ****************************************
   typedef enum logic [2:0] {
      CBCD_SH_LSL = 3'd0,
      CBCD_SH_LSR = 3'd1,
      CBCD_SH_ASR = 3'd2,
      CBCD_SH_ROR = 3'd3,
      CBCD_SH_RRX = 3'd4
   } cbcd_shift_type;

   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } cbcd_flags_type;

   typedef struct packed {
      logic        valid;
      logic        alt;      // Second variant
      logic [3:0]  cpNum;
      logic [3:0]  opcodeA;
      logic [2:0]  opcodeB;
      logic [31:0] word;
   } cbcd_coproc_type;

   typedef struct packed {
      logic        valid;
      logic        wide;
      logic [31:0] word;
      logic [31:0] addr;
      logic        condPass;
   } cbcd_instr_type;

endpackage : cbcd_pkg

// ### logic/cbcd_leading_zero.sv
// Counts zero bits above the most significant one of a 32-bit word.
// Assumes a purely combinational caller on the same clock.
`timescale 1ns/1ps
module cbcd_leading_zero (
   input  wire logic [31:0] value,
   output logic      [5:0]  count
);
   import cbcd_pkg::*;

   // ****************************************
   // Priority scan from bit 0 upward; the top set bit wins
   // ****************************************
   logic [5:0] stage [0:32];
   assign stage[0] = CBCD_ZERO_COUNT;   // Zero source gives 32
   generate
      for (genvar b = 0; b < 32; b++) begin : gScan
         assign stage[b + 1] = value[b] ? 6'(31 - b) : stage[b];
      end
   endgenerate
   assign count = stage[32];

endmodule : cbcd_leading_zero

// ### logic/cbcd_const_expand.sv
// Modified-constant expansion and shifter for compare-negative operands.
// Assumes the caller supplies the current carry flag for rotate-with-extend.
`timescale 1ns/1ps
module cbcd_const_expand (
   input  wire logic [11:0]              immField,
   input  wire logic [31:0]              regValue,
   input  wire cbcd_pkg::cbcd_shift_type shiftKind,
   input  wire logic [5:0]               shiftAmt,
   input  wire logic                     carryIn,
   output logic      [31:0]              constValue,
   output logic      [31:0]              shiftedValue
);
   import cbcd_pkg::*;

   // ****************************************
   // Constant expansion
   // ****************************************
   always_comb begin
      logic [31:0] base;
      base = {24'h00_0000, 1'b1, immField[6:0]};
      constValue = 32'h0000_0000;
      if (immField[11:10] == 2'b00) begin
         case (immField[9:8])
            2'b00:   constValue = {24'h00_0000, immField[7:0]};
            2'b01:   constValue = {8'h00, immField[7:0], 8'h00, immField[7:0]};
            2'b10:   constValue = {immField[7:0], 8'h00, immField[7:0], 8'h00};
            default: constValue = {4{immField[7:0]}};
         endcase
      end else begin
         constValue = (base >> immField[11:7]) | (base << (6'd32 - {1'b0, immField[11:7]}));
      end
   end

   // ****************************************
   // Register shifter
   // ****************************************
   always_comb begin
      logic [63:0] ext;
      ext = {{32{regValue[31]}}, regValue};
      shiftedValue = regValue;
      case (shiftKind)
         CBCD_SH_LSL: shiftedValue = regValue << shiftAmt;
         CBCD_SH_LSR: shiftedValue = regValue >> shiftAmt;
         CBCD_SH_ASR: shiftedValue = 32'(ext >> shiftAmt);
         CBCD_SH_ROR: shiftedValue = (regValue >> shiftAmt[4:0]) | (regValue << (6'd32 - {1'b0, shiftAmt[4:0]}));
         CBCD_SH_RRX: shiftedValue = {carryIn, regValue[31:1]};
         default:     shiftedValue = regValue;
      endcase
   end

endmodule : cbcd_const_expand

// ### logic/cbcd_decode.sv
// Decode and execute stage for compare-branch, coprocessor dispatch,
// clear-exclusive, count-leading-zeros and compare-negative.
// Assumes the core supplies register values read by the indices it outputs
// combinationally, and that conditional-block placement is already legal.
// Results are one-cycle registered pulses.
// Coprocessor work takes two cycles.
// Register indices answer in the same cycle.
// Unknown encodings are ignored.
`timescale 1ns/1ps
module cbcd_decode (
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   input  wire cbcd_pkg::cbcd_instr_type instr,
   output logic      [3:0]               readIdxA,
   output logic      [3:0]               readIdxB,
   input  wire logic [31:0]              readDataA,
   input  wire logic [31:0]              readDataB,
   input  wire cbcd_pkg::cbcd_flags_type flagsIn,
   output cbcd_pkg::cbcd_flags_type      flagsOut,
   output logic                          flagsWrite,
   output logic                          pcWrite,
   output logic      [31:0]              pcTarget,
   output logic                          regWrite,
   output logic      [3:0]               regWriteIdx,
   output logic      [31:0]              regWriteData,
   output cbcd_pkg::cbcd_coproc_type     coprocOffer,
   input  wire logic                     coprocAccept,
   output logic                          usage_error_exception,
   output logic                          monitorClear,
   output logic                          unpredictable,
   output logic                          instrDone
);
   import cbcd_pkg::*;

   // ****************************************
   // Classes and dispatch state
   // ****************************************
   // One-hot codes; default recovers to idle
   typedef enum logic [2:0] {
      CBCD_ST_IDLE  = 3'b001,
      CBCD_ST_OFFER = 3'b010,
      CBCD_ST_DONE  = 3'b100
   } cbcd_state_type;

   cbcd_state_type state_r;
   cbcd_state_type state_nxt;

   // Instruction views and class strobes
   logic [15:0] hw;
   logic [31:0] w;
   logic        isBranch;
   logic        isCoproc;
   logic        isClrex;
   logic        isClz;
   logic        isCmnImm;
   logic        isCmnR16;
   logic        isCmnR32;
   logic        isCmn;
   logic        go;

   // Halfword views and class match
   assign hw       = instr.word[15:0];
   assign w        = instr.word;
   assign go       = instr.valid && state_r == CBCD_ST_IDLE;
   // Class match per group
   assign isBranch = !instr.wide && (hw & CBCD_BR_MASK) == CBCD_BR_MATCH;
   assign isCmnR16 = !instr.wide && (hw & CBCD_CMNR16_MASK) == CBCD_CMNR16_MATCH;
   assign isCoproc = instr.wide && (w & CBCD_CDP_MASK) == CBCD_CDP_MATCH;
   assign isClrex  = instr.wide && (w & CBCD_CLEAR_EXCLUSIVE_MONITOR_MASK) == CBCD_CLEAR_EXCLUSIVE_MONITOR_MATCH;
   assign isClz    = instr.wide && (w & CBCD_CLZ_MASK) == CBCD_CLZ_MATCH;
   assign isCmnImm = instr.wide && (w & CBCD_CMNI_MASK) == CBCD_CMNI_MATCH;
   assign isCmnR32 = instr.wide && (w & CBCD_CMNR32_MASK) == CBCD_CMNR32_MATCH;
   assign isCmn    = isCmnImm || isCmnR16 || isCmnR32;

   // ****************************************
   // Register read selection
   // ****************************************
   // Port A: tested or first operand
   // Port B: shifted or counted operand
   always_comb begin
      readIdxA = 4'h0;
      readIdxB = 4'h0;
      if (isBranch) begin
         readIdxA = {1'b0, hw[2:0]};
      end else if (isCmnR16) begin
         readIdxA = {1'b0, hw[2:0]};
         readIdxB = {1'b0, hw[5:3]};
      end else if (isClz) begin
         readIdxB = w[3:0];
      end else if (isCmnImm || isCmnR32) begin
         readIdxA = w[19:16];
         readIdxB = w[3:0];
      end
   end

   // ****************************************
   // Compare-and-branch evaluation
   // ****************************************
   logic [31:0] branchOffset;
   logic [31:0] branchBase;
   logic        branchNonZero;
   logic        branchTaken;

   // Even offset, 0 to 126 forward
   // Base is address plus four
   assign branchOffset  = {25'h000_0000, hw[CBCD_POS_BR_I], hw[7:3], 1'b0};
   assign branchNonZero = hw[CBCD_POS_POLARITY];
   assign branchBase    = instr.addr + CBCD_PC_AHEAD_W;
   assign branchTaken   = branchNonZero ^ (readDataA == 32'h0000_0000);

   // ****************************************
   // Compare-negative operands and adder
   // ****************************************
   cbcd_shift_type shiftKind;
   logic [5:0]     shiftAmt;
   logic [4:0]     shiftField;
   logic [31:0]    constValue;
   logic [31:0]    shiftedValue;
   logic [31:0]    operandB;
   logic [32:0]    sum;
   logic [31:0]    result;

   // Amount field of the wide form
   assign shiftField = {w[14:12], w[7:6]};

   // Shift kind and amount from type and amount fields
   always_comb begin
      shiftKind = CBCD_SH_LSL;
      shiftAmt  = 6'h00;
      if (isCmnR32) begin
         case (w[5:4])
            // Logical left, amount as coded
            2'b00: begin
               shiftKind = CBCD_SH_LSL;
               shiftAmt  = {1'b0, shiftField};
            end
            // Logical right, zero means 32
            2'b01: begin
               shiftKind = CBCD_SH_LSR;
               shiftAmt  = (shiftField == 5'h00) ? 6'h20 : {1'b0, shiftField};
            end
            // Arithmetic right, zero means 32
            2'b10: begin
               shiftKind = CBCD_SH_ASR;
               shiftAmt  = (shiftField == 5'h00) ? 6'h20 : {1'b0, shiftField};
            end
            // Rotate; zero rotates through carry
            default: begin
               shiftKind = (shiftField == 5'h00) ? CBCD_SH_RRX : CBCD_SH_ROR;
               shiftAmt  = (shiftField == 5'h00) ? 6'h01 : {1'b0, shiftField};
            end
         endcase
      end
   end

   // Shared expander and shifter
   // Carry feeds the extend rotate
   cbcd_const_expand uExpand (
      .immField     ({w[26], w[14:12], w[7:0]}),
      .regValue     (readDataB),
      .shiftKind    (shiftKind),
      .shiftAmt     (shiftAmt),
      .carryIn      (flagsIn.c),
      .constValue   (constValue),
      .shiftedValue (shiftedValue)
   );

   // Carry-in zero; sum never written back
   // Flags from the 33-bit sum
   assign operandB = isCmnImm ? constValue : shiftedValue;
   assign sum      = {1'b0, readDataA} + {1'b0, operandB};
   assign result   = sum[31:0];

   // ****************************************
   // Leading-zero count
   // ****************************************
   logic [5:0] lzCount;

   // Counts the port B operand
   cbcd_leading_zero uLeadingZero (
      .value (readDataB),
      .count (lzCount)
   );

   // ****************************************
   // Unpredictable encodings
   // ****************************************
   logic unpredNow;

   // Flagged only, never blocks execution
   // Mismatched source copies flagged too
   always_comb begin
      unpredNow = 1'b0;
      if (isClz) begin
         unpredNow = (w[19:16] != w[3:0])
                  || w[11:8] == 4'(CBCD_POS_SP) || w[11:8] == 4'(CBCD_POS_PC)
                  || w[3:0] == 4'(CBCD_POS_SP) || w[3:0] == 4'(CBCD_POS_PC);
      end else if (isCmnImm) begin
         unpredNow = w[19:16] == 4'(CBCD_POS_PC);
      end else if (isCmnR32) begin
         unpredNow = w[19:16] == 4'(CBCD_POS_PC)
                  || w[3:0] == 4'(CBCD_POS_SP) || w[3:0] == 4'(CBCD_POS_PC);
      end
   end

   // ****************************************
   // Coprocessor dispatch state machine
   // ****************************************
   // Leaves idle only for a passing coprocessor word
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CBCD_ST_IDLE: begin
            if (go && isCoproc && instr.condPass) begin
               state_nxt = CBCD_ST_OFFER;
            end
         end
         // Offer cycle, then answer cycle
         CBCD_ST_OFFER: begin
            state_nxt = CBCD_ST_DONE;
         end
         CBCD_ST_DONE: begin
            state_nxt = CBCD_ST_IDLE;
         end
         default: begin
            state_nxt = CBCD_ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r <= CBCD_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Offer held one cycle while the coprocessor answers
   // Fields stay readable after the pulse
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         coprocOffer <= '0;
      end else if (go && isCoproc && instr.condPass) begin
         coprocOffer.valid   <= 1'b1;
         coprocOffer.alt     <= w[CBCD_POS_ALT];
         coprocOffer.cpNum   <= w[11:8];
         coprocOffer.opcodeA <= w[23:20];
         coprocOffer.opcodeB <= w[7:5];
         coprocOffer.word    <= w;
      end else begin
         coprocOffer.valid <= 1'b0;
      end
   end

   // Refusal turns into a usage error
   // Answer sampled while the offer stands
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         usage_error_exception <= 1'b0;
      end else begin
         usage_error_exception <= state_r == CBCD_ST_OFFER && !coprocAccept;
      end
   end

   // ****************************************
   // Branch and flag results
   // ****************************************
   // Target every cycle; strobe qualifies it
   // Condition pass ignored for branches
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pcWrite  <= 1'b0;
         pcTarget <= CBCD_RESET_WORD;
      end else begin
         pcWrite  <= go && isBranch && branchTaken;
         pcTarget <= branchBase + branchOffset;
      end
   end

   // Flags held between compares
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flagsWrite <= 1'b0;
         flagsOut   <= CBCD_RESET_FLAGS;
      end else begin
         flagsWrite <= go && isCmn && instr.condPass;
         if (go && isCmn && instr.condPass) begin
            flagsOut.n <= result[31];
            flagsOut.z <= result == 32'h0000_0000;
            flagsOut.c <= sum[32];
            // Like-signed operands, unlike-signed sum
            flagsOut.v <= (readDataA[31] == operandB[31]) && (result[31] != readDataA[31]);
         end
      end
   end

   // ****************************************
   // Register writeback and monitor clear
   // ****************************************
   // Count fits six bits, zero-extended
   // Index and data follow every cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         regWrite     <= 1'b0;
         regWriteIdx  <= 4'h0;
         regWriteData <= CBCD_RESET_WORD;
      end else begin
         regWrite     <= go && isClz && instr.condPass;
         regWriteIdx  <= w[11:8];
         regWriteData <= {26'h000_0000, lzCount};
      end
   end

   // Local exclusive record clear strobe
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         monitorClear <= 1'b0;
      end else begin
         monitorClear <= go && isClrex && instr.condPass;
      end
   end

   // Unpredictable register use strobe
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         unpredictable <= 1'b0;
      end else begin
         unpredictable <= go && unpredNow;
      end
   end

   // Completion strobe for every handled instruction but a coprocessor word whose condition fails
   // Coprocessor work ends in the answer cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         instrDone <= 1'b0;
      end else begin
         instrDone <= (go && (isBranch || isClrex || isClz || isCmn))
                   || state_r == CBCD_ST_OFFER;
      end
   end

endmodule : cbcd_decode

// ### bench/cbcd_coproc_model.sv
// Coprocessor stand-in that answers dispatched data operations.
// Assumes offers arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps
module cbcd_coproc_model (
   input  wire logic                      clk_sys,
   input  wire logic                      reset,
   input  wire cbcd_pkg::cbcd_coproc_type coprocOffer,
   input  wire logic [15:0]               acceptMask,
   output logic                           coprocAccept
);
   import cbcd_pkg::*;
   // *****
   // Answer logic
   // *****
   logic idleToggle_r;
   // Idle level flips so a stale answer never looks valid
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) idleToggle_r <= 1'b0;
      else idleToggle_r <= ~idleToggle_r;
   end
   // Only units present in the mask accept
   assign coprocAccept = coprocOffer.valid ? acceptMask[coprocOffer.cpNum] : idleToggle_r;
endmodule : cbcd_coproc_model

// ### bench/cbcd_checker.sv
// Port-level assertions for the decode block.
// Assumes it is bound to the decode module on its core clock.
`timescale 1ns/1ps
module cbcd_checker (
   input wire logic                      clk_sys,
   input wire logic                      reset,
   input wire cbcd_pkg::cbcd_instr_type  instr,
   input wire cbcd_pkg::cbcd_flags_type  flagsOut,
   input wire logic                      flagsWrite,
   input wire logic                      pcWrite,
   input wire logic [31:0]               pcTarget,
   input wire logic                      regWrite,
   input wire logic [31:0]               regWriteData,
   input wire cbcd_pkg::cbcd_coproc_type coprocOffer,
   input wire logic                      coprocAccept,
   input wire logic                      usage_error_exception,
   input wire logic                      monitorClear,
   input wire logic                      instrDone
);
   import cbcd_pkg::*;
   // *****
   // Assertions
   // *****
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_branch_range: assert property (pcWrite |-> ((pcTarget - $past(instr.addr) - 32'h0000_0004) & 32'hFFFF_FF81) == 0)
      else $error("branch target outside forward even range");
   a_branch_no_flags: assert property (pcWrite |-> !flagsWrite)
      else $error("branch wrote flags");
   a_branch_short: assert property (pcWrite |-> $past(instr.valid) && !$past(instr.wide))
      else $error("branch without short instruction");
   a_offer_fields: assert property (coprocOffer.valid |-> coprocOffer.cpNum == coprocOffer.word[11:8]
      && coprocOffer.opcodeA == coprocOffer.word[23:20] && coprocOffer.opcodeB == coprocOffer.word[7:5]
      && coprocOffer.alt == coprocOffer.word[28]) else $error("offer fields disagree with word");
   a_refuse_fault: assert property (coprocOffer.valid && !coprocAccept |=> usage_error_exception && instrDone)
      else $error("refused offer without fault");
   a_accept_quiet: assert property (coprocOffer.valid && coprocAccept |=> !usage_error_exception && instrDone)
      else $error("accepted offer faulted");
   a_fault_cause: assert property (usage_error_exception |-> $past(coprocOffer.valid) && !$past(coprocAccept))
      else $error("fault without refused offer");
   a_clz_range: assert property (regWrite |-> regWriteData <= 32'h0000_0020)
      else $error("leading zero count above 32");
   a_flags_gated: assert property (flagsWrite |-> $past(instr.condPass))
      else $error("flags written with failed condition");
   a_clear_cause: assert property (monitorClear |-> $past(instr.word) == CBCD_CLEAR_EXCLUSIVE_MONITOR_MATCH && $past(instr.condPass))
      else $error("monitor cleared without clear instruction");
   c_branch: cover property (pcWrite);
   c_fault: cover property (usage_error_exception);
   c_zero_flag: cover property (flagsWrite && flagsOut.z);
endmodule : cbcd_checker

// ### bench/tb_top.sv
// Self-checking bench for the decode block and a coprocessor stand-in.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_top;
   import cbcd_pkg::*;
   logic            clk_sys, reset, flagsWrite, pcWrite, regWrite, coprocAccept;
   logic            usage_error_exception, monitorClear, unpredictable, instrDone;
   logic            sPc, sFl, sRw, sMon, sFlt, sUnp;
   cbcd_instr_type  instr;
   cbcd_flags_type  flagsIn, flagsOut, fl;
   cbcd_coproc_type coprocOffer, off;
   logic [3:0]      readIdxA, readIdxB, regWriteIdx, rwIdx;
   logic [31:0]     readDataA, readDataB, pcTarget, regWriteData, pcT, rwData;
   logic [15:0]     acceptMask;
   logic [31:0]     regs [16];
   int              failures = 0;
   int              checks_done = 0;
   // *****
   // Design, register file and partner
   // *****
   assign readDataA = regs[readIdxA];
   assign readDataB = regs[readIdxB];
   cbcd_decode DUT (.clk_sys(clk_sys), .reset(reset), .instr(instr), .readIdxA(readIdxA), .readIdxB(readIdxB),
      .readDataA(readDataA), .readDataB(readDataB), .flagsIn(flagsIn), .flagsOut(flagsOut),
      .flagsWrite(flagsWrite), .pcWrite(pcWrite), .pcTarget(pcTarget), .regWrite(regWrite),
      .regWriteIdx(regWriteIdx), .regWriteData(regWriteData), .coprocOffer(coprocOffer),
      .coprocAccept(coprocAccept), .usage_error_exception(usage_error_exception), .monitorClear(monitorClear),
      .unpredictable(unpredictable), .instrDone(instrDone));
   cbcd_coproc_model u_cop (.clk_sys(clk_sys), .reset(reset), .coprocOffer(coprocOffer),
      .acceptMask(acceptMask), .coprocAccept(coprocAccept));
   // Free-running core clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // *****
   // Shared tasks
   // *****
   function automatic logic [3:0] nzcv(input logic [31:0] a, input logic [31:0] b);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b};
      return {s[31], s[31:0] == 0, s[32], (a[31] == b[31]) && (s[31] != a[31])};
   endfunction : nzcv
   // One instruction, collecting every pulse until done
   task automatic run(input logic wide, input logic [31:0] word, input logic cond);
      {sPc, sFl, sRw, sMon, sFlt, sUnp} = '0;
      off = '0;
      @(negedge clk_sys);
      instr = '{valid: 1'b1, wide: wide, word: word, addr: 32'h0000_1000, condPass: cond};
      for (int i = 0; i < 6; i++) begin
         @(negedge clk_sys);
         instr.valid = 1'b0;
         if (pcWrite === 1'b1) begin sPc = 1'b1; pcT = pcTarget; end
         if (flagsWrite === 1'b1) begin sFl = 1'b1; fl = flagsOut; end
         if (regWrite === 1'b1) begin sRw = 1'b1; rwIdx = regWriteIdx; rwData = regWriteData; end
         if (coprocOffer.valid === 1'b1) off = coprocOffer;
         sMon |= (monitorClear === 1'b1);
         sFlt |= (usage_error_exception === 1'b1);
         sUnp |= (unpredictable === 1'b1);
         if (instrDone === 1'b1) break;
      end
      if (cond) `CHK("done", 1'b1, instrDone)
   endtask : run
   task end_of_test();
      if (failures == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // *****
   // Scenarios
   // *****
   task automatic t_branch();
      logic [15:0] hw [4] = '{16'hB3F8, 16'hB3F8, 16'hB909, 16'hB909};
      logic [31:0] rv [4] = '{32'h0000_0000, 32'h0000_0005, 32'h0000_0005, 32'h0000_0000};
      logic [31:0] ofs [4] = '{32'h0000_007E, 32'h0000_007E, 32'h0000_0002, 32'h0000_0002};
      logic        tk [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int k = 0; k < 4; k++) begin
         regs[k / 2] = rv[k];
         run(1'b0, {16'h0000, hw[k]}, 1'b1);
         `CHK("branch taken", tk[k], sPc)
         if (tk[k]) `CHK("branch target", 32'h0000_1004 + ofs[k], pcT)
         `CHK("branch flags", 1'b0, sFl)
      end
   endtask : t_branch
   task automatic t_clz();
      logic [31:0] v [4] = '{32'h0000_0000, 32'h0000_0001, 32'h8000_0000, 32'h0001_FFFF};
      logic [31:0] c [4] = '{32'h0000_0020, 32'h0000_001F, 32'h0000_0000, 32'h0000_000F};
      for (int k = 0; k < 4; k++) begin
         regs[5] = v[k];
         run(1'b1, 32'hFAB5_F685, 1'b1);
         `CHK("clz write", 1'b1, sRw)
         `CHK("clz legal", 1'b0, sUnp)
         `CHK("clz index", 4'h6, rwIdx)
         `CHK("clz count", c[k], rwData)
      end
      run(1'b1, 32'hFAB1_FD81, 1'b1);
      `CHK("clz reg13", 1'b1, sUnp)
   endtask : t_clz
   task automatic t_cmn();
      logic [31:0] w [5] = '{32'hEB13_1F04, 32'hEB13_1F14, 32'hEB13_1F24, 32'hEB13_1F34, 32'hEB13_0F34};
      logic [31:0] sh [5] = '{32'h0000_0110, 32'h0800_0001, 32'hF800_0001, 32'h1800_0001, 32'hC000_0008};
      regs[2] = 32'hFF7F_FF80;
      run(1'b1, 32'hF112_1F80, 1'b1);
      `CHK("cmn imm flags", nzcv(32'hFF7F_FF80, 32'h0080_0080), fl)
      `CHK("cmn no write", 1'b0, sRw)
      run(1'b1, 32'hF112_1F80, 1'b0);
      `CHK("cmn skipped", 1'b0, sFl)
      regs[1] = 32'h7FFF_FFFF;
      regs[2] = 32'h0000_0001;
      run(1'b0, 32'h0000_42D1, 1'b1);
      `CHK("cmn short flags", nzcv(32'h7FFF_FFFF, 32'h0000_0001), fl)
      regs[3] = 32'h0000_0001;
      regs[4] = 32'h8000_0011;
      for (int k = 0; k < 5; k++) begin
         run(1'b1, w[k], 1'b1);
         `CHK("cmn shift flags", nzcv(32'h0000_0001, sh[k]), fl)
      end
      run(1'b1, 32'hF11F_0F00, 1'b1);
      `CHK("cmn imm pc", 1'b1, sUnp)
      run(1'b1, 32'hEB13_1F0D, 1'b1);
      `CHK("cmn reg sp", 1'b1, sUnp)
   endtask : t_cmn
   task automatic t_coproc();
      run(1'b1, 32'hEEF1_23E4, 1'b1);
      `CHK("cdp offer", {1'b1, 1'b0, 4'h3, 4'hF, 3'h7, 32'hEEF1_23E4}, off)
      `CHK("cdp fault", 1'b0, sFlt)
      @(negedge clk_sys);
      run(1'b1, 32'hFE01_2504, 1'b1);
      `CHK("cdp alt offer", {1'b1, 1'b1, 4'h5, 4'h0, 3'h0, 32'hFE01_2504}, off)
      `CHK("cdp alt fault", 1'b1, sFlt)
      @(negedge clk_sys);
   endtask : t_coproc
   task automatic t_clear_exclusive_monitor();
      run(1'b1, 32'hF3BF_8F2F, 1'b1);
      `CHK("clear done", 1'b1, sMon)
      run(1'b1, 32'hF3BF_8F2F, 1'b0);
      `CHK("clear skipped", 1'b0, sMon)
   endtask : t_clear_exclusive_monitor
   // Main sequence
   initial begin
      reset = 1'b1;
      instr = '0;
      flagsIn = 4'h2;
      acceptMask = 16'h0008;
      for (int k = 0; k < 16; k++) regs[k] = 32'h0000_0000;
      repeat (6) @(negedge clk_sys);
      reset = 1'b0;
      t_branch();
      t_clz();
      t_cmn();
      t_coproc();
      t_clear_exclusive_monitor();
      end_of_test();
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (2000) @(posedge clk_sys);
      failures++;
      end_of_test();
   end
endmodule : tb_top
bind cbcd_decode cbcd_checker u_chk (.clk_sys(clk_sys), .reset(reset), .instr(instr), .flagsOut(flagsOut),
   .flagsWrite(flagsWrite), .pcWrite(pcWrite), .pcTarget(pcTarget), .regWrite(regWrite),
   .regWriteData(regWriteData), .coprocOffer(coprocOffer), .coprocAccept(coprocAccept),
   .usage_error_exception(usage_error_exception), .monitorClear(monitorClear), .instrDone(instrDone));
